/* File: rtl/cspc_defines.svh */
// Constants for the coherent slave port: widths, offsets, fields, encodings
`ifndef CSPC_DEFINES_SVH
`define CSPC_DEFINES_SVH

`define CSPC_DATA_W        128
`define CSPC_STRB_W        16
`define CSPC_ID_W          8
`define CSPC_ADDR_W        32
`define CSPC_MEM_DEPTH     16
`define CSPC_MEM_IDX_LSB   4
`define CSPC_MEM_IDX_W     4
`define CSPC_WFIFO_DEPTH   4
`define CSPC_WFIFO_PTR_W   2
`define CSPC_WFIFO_LVL_W   3
`define CSPC_WFIFO_ROOM    3'h3

`define CSPC_REG_CTRL      32'h0000_0000
`define CSPC_REG_SNADDR    32'h0000_0004
`define CSPC_REG_SNCMD     32'h0000_0008
`define CSPC_REG_STATUS    32'h0000_000c
`define CSPC_REG_SNDATA    32'h0000_0010
`define CSPC_REG_IDENT     32'h0000_0014

`define CSPC_CTRL_DVM_BIT  0
`define CSPC_CTRL_SNP_BIT  1
`define CSPC_CTRL_RST      2'h0
`define CSPC_CMD_TYPE_LSB  0
`define CSPC_CMD_PROT_LSB  4

`define CSPC_ST_BUSY_BIT   0
`define CSPC_ST_CRESP_LSB  1
`define CSPC_ST_CDSEEN_BIT 6
`define CSPC_ST_CHEN_LSB   7
`define CSPC_ST_PORT_LSB   9
`define CSPC_ST_RACK_LSB   12
`define CSPC_ST_WACK_LSB   20
`define CSPC_ST_FULL_BIT   28

`define CSPC_AW_EVICT      3'h4
`define CSPC_AR_DVM_MSG    4'hf
`define CSPC_AC_DVM_CMPL   4'he
`define CSPC_RESP_OKAY     2'h0
`define CSPC_PORT_MAX      3'h6

`endif

/* File: rtl/cspc_pkg.sv */
// Types shared by the coherent slave port
`include "cspc_defines.svh"

package cspc_pkg;

  // Gray along idle, address, response, data
  typedef enum logic [1:0] {
    CSPC_SN_IDLE = 2'h0,
    CSPC_SN_ADDR = 2'h1,
    CSPC_SN_RESP = 2'h3,
    CSPC_SN_DATA = 2'h2
  } cspc_snoop_phase_type;

  typedef logic [`CSPC_MEM_DEPTH-1:0][`CSPC_DATA_W-1:0] cspc_mem_type;

  typedef struct packed {
    logic                       cfgDone;
    logic [1:0]                 chanEn;
    logic [1:0]                 swEn;
    logic                       apbReady;
    logic                       apbErr;
    logic [31:0]                apbRdata;
    logic                       awReady;
    logic                       wrActive;
    logic [`CSPC_ID_W-1:0]      wrId;
    logic                       wrTrace;
    logic [`CSPC_MEM_IDX_W-1:0] wrIdx;
    logic                       bValid;
    logic [`CSPC_ID_W-1:0]      bId;
    logic                       bTrace;
    logic                       arReady;
    logic                       rValid;
    logic [`CSPC_ID_W-1:0]      rId;
    logic                       rTrace;
    logic                       rLast;
    logic [7:0]                 rCnt;
    logic [`CSPC_MEM_IDX_W-1:0] rIdx;
    logic [`CSPC_DATA_W-1:0]    rData;
    logic [`CSPC_STRB_W-1:0]    rCheck;
    cspc_snoop_phase_type       phase;
    logic                       acValid;
    logic [`CSPC_ADDR_W-1:0]    acAddr;
    logic [2:0]                 acProt;
    logic [3:0]                 acSnoop;
    logic [3:0]                 acVmid;
    logic                       crReady;
    logic                       cdReady;
    logic                       cdSeen;
    logic [4:0]                 crResp;
    logic [31:0]                cdWord;
    logic [`CSPC_ADDR_W-1:0]    snAddr;
    logic [7:0]                 rdAcks;
    logic [7:0]                 wrAcks;
    logic [11:0]                idents;
    cspc_mem_type               mem;
  } cspc_state_type;

endpackage

/* File: rtl/cspc_wresp_fifo.sv */
// Small queue of pending write responses, identifier and trace bit
`timescale 1ns/100ps
`include "cspc_defines.svh"

module cspc_wresp_fifo (
  // Clock and reset
  input  logic                         clk,
  input  logic                         arst_n,
  // Fill side
  input  logic                         push,
  input  logic [`CSPC_ID_W:0]          din,
  // Drain side
  input  logic                         pop,
  output logic [`CSPC_ID_W:0]          dout,
  output logic                         empty,
  output logic [`CSPC_WFIFO_LVL_W-1:0] level
);

  typedef struct packed {
    logic [`CSPC_WFIFO_DEPTH-1:0][`CSPC_ID_W:0] slot;
    logic [`CSPC_WFIFO_PTR_W-1:0]              wrPtr;
    logic [`CSPC_WFIFO_PTR_W-1:0]              rdPtr;
    logic [`CSPC_WFIFO_LVL_W-1:0]              count;
  } cspc_fifo_state_type;

  cspc_fifo_state_type st;
  cspc_fifo_state_type next_st;
  logic                doPush;
  logic                doPop;

  // Pushing into a full queue is dropped; the port never asks for it
  assign doPush = push && (st.count != `CSPC_WFIFO_LVL_W'(`CSPC_WFIFO_DEPTH));
  assign doPop  = pop && (st.count != '0);

  always_comb begin
    next_st = st;
    if (doPush) begin
      next_st.slot[st.wrPtr] = din;
      next_st.wrPtr          = st.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    next_st.count = st.count + {2'h0, doPush} - {2'h0, doPop};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout  = st.slot[st.rdPtr];
  assign empty = (st.count == '0);
  assign level = st.count;

endmodule

/* File: rtl/cspc_port.sv */
// Coherent slave port: request, response, snoop and acknowledge channels
//
// Contract
// [RQ1] Port index is a build parameter limited to the range 0 to 6.
// [RQ2] Write data is 128 bits with 16 byte-lane strobes.
// [RQ3] Master marks the final write beat; the port closes the burst there.
// [RQ4] Write response returns the address-phase trace bit, except for Evicts.
// [RQ5] Read data returns the trace bit of its read request.
// [RQ6] Snoop VMID copies the read-request VMID, except for DVM Complete.
// [RQ7] Read response is four bits on full-coherent, two on I/O-coherent ports; the code drives four bits on both, upper two zero.
// [RQ8] Only full-coherent ports take 128-bit snoop data with a last marker.
// [RQ9] Snoop data ready is high only when a beat can be taken.
// [RQ10] Master answers each snoop with a 5-bit response under valid/ready.
// [RQ11] Snoops leave on an address channel with 3-bit protection, 4-bit type.
// [RQ12] Full-coherent master acknowledges reads and writes on separate inputs.
// [RQ13] Master supplies write/read snoop types and 2-bit shareability domains.
// [RQ14] Region inputs may be tied to zero when the master lacks them.
// [RQ15] Master may add 4-bit access identifiers to requests and snoop responses.
// [RQ16] Every accepted write completes on the write response channel.
// [RQ17] Channel enables override software: bit 0 DVM, bit 1 snoops.
// [RQ18] Configuration inputs are captured only as reset is released.
// [RQ19] A beat moves only when valid and ready are both high.
// [RQ20] Response identifiers equal the request identifier, in order.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "cspc_defines.svh"

module cspc_port #(
  parameter bit         FULL_COHERENT = 1'b1,
  parameter logic [2:0] PORT_INDEX    = 3'h0
) (
  // Clock and reset
  input  logic                       clk,
  input  logic                       arst_n,
  // Configuration
  input  logic [1:0]                 snoop_channel_enables,
  // APB register bus
  input  logic                       psel,
  input  logic                       penable,
  input  logic                       pwrite,
  input  logic [31:0]                paddr,
  input  logic [31:0]                pwdata,
  input  logic [3:0]                 pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Write address
  input  logic                       awvalid,
  output logic                       awready,
  input  logic [`CSPC_ID_W-1:0]      awid,
  input  logic [`CSPC_ADDR_W-1:0]    awaddr,
  input  logic [2:0]                 awsnoop,
  input  logic [1:0]                 awdomain,
  input  logic [3:0]                 awregion,
  input  logic                       write_req_trace_in,
  input  logic [3:0]                 write_req_access_ident,
  // Write data
  input  logic                       wvalid,
  output logic                       wready,
  input  logic [`CSPC_DATA_W-1:0]    wdata,
  input  logic [`CSPC_STRB_W-1:0]    wstrb,
  input  logic                       wlast,
  input  logic [`CSPC_STRB_W-1:0]    write_data_check,
  // Write response
  output logic                       bvalid,
  input  logic                       bready,
  output logic [`CSPC_ID_W-1:0]      bid,
  output logic [1:0]                 bresp,
  output logic                       write_resp_trace_out,
  // Read address
  input  logic                       arvalid,
  output logic                       arready,
  input  logic [`CSPC_ID_W-1:0]      arid,
  input  logic [`CSPC_ADDR_W-1:0]    araddr,
  input  logic [7:0]                 arlen,
  input  logic [2:0]                 arprot,
  input  logic [3:0]                 arsnoop,
  input  logic [1:0]                 ardomain,
  input  logic [3:0]                 arregion,
  input  logic                       read_req_trace_in,
  input  logic [3:0]                 read_req_access_ident,
  input  logic [3:0]                 read_req_vmid_ext,
  // Read data
  output logic                       rvalid,
  input  logic                       rready,
  output logic [`CSPC_ID_W-1:0]      rid,
  output logic [`CSPC_DATA_W-1:0]    rdata,
  output logic [3:0]                 rresp,
  output logic                       rlast,
  output logic [`CSPC_STRB_W-1:0]    read_data_check,
  output logic                       read_resp_trace_out,
  // Snoop address
  output logic                       acvalid,
  input  logic                       acready,
  output logic [`CSPC_ADDR_W-1:0]    acaddr,
  output logic [2:0]                 acprot,
  output logic [3:0]                 acsnoop,
  output logic [3:0]                 snoop_vmid_ext,
  // Snoop response
  input  logic                       crvalid,
  output logic                       crready,
  input  logic [4:0]                 crresp,
  input  logic [3:0]                 snoop_resp_access_ident,
  // Snoop data
  input  logic                       cdvalid,
  output logic                       cdready,
  input  logic [`CSPC_DATA_W-1:0]    cddata,
  input  logic                       cdlast,
  input  logic [`CSPC_STRB_W-1:0]    snoop_data_check,
  // Acknowledges
  input  logic                       rack,
  input  logic                       wack
);

  import cspc_pkg::*;

  cspc_state_type              st;
  cspc_state_type              next_st;
  logic                        apbSetup;
  logic                        apbAccess;
  logic                        awHs;
  logic                        wHs;
  logic                        bHs;
  logic                        arHs;
  logic                        rHs;
  logic                        acHs;
  logic                        crHs;
  logic                        cdHs;
  logic                        arIsDvm;
  logic                        dvmOn;
  logic                        snoopOn;
  logic [`CSPC_MEM_IDX_W-1:0]  loadIdx;
  logic [`CSPC_DATA_W-1:0]     loadWord;
  logic [`CSPC_STRB_W-1:0]     loadCheck;
  logic [`CSPC_DATA_W-1:0]     oldWord;
  logic [`CSPC_DATA_W-1:0]     mergedWord;
  logic [31:0]                 statusWord;
  logic                        fifoPush;
  logic                        fifoPop;
  logic [`CSPC_ID_W:0]         fifoIn;
  logic [`CSPC_ID_W:0]         fifoOut;
  logic                        fifoEmpty;
  logic [`CSPC_WFIFO_LVL_W-1:0] fifoLevel;

  // ****
  // Handshakes
  // ****
  // [RQ19] Valid and ready
  assign awHs = awvalid && st.awReady;
  assign wHs  = wvalid && st.wrActive;
  assign bHs  = st.bValid && bready;
  assign arHs = arvalid && st.arReady;
  assign rHs  = st.rValid && rready;
  assign acHs = st.acValid && acready;
  assign crHs = crvalid && st.crReady;
  assign cdHs = cdvalid && st.cdReady;

  assign apbSetup  = psel && !penable;
  assign apbAccess = psel && penable && st.apbReady;

  assign arIsDvm = (arsnoop == `CSPC_AR_DVM_MSG);
  // [RQ17] Pins gate the software enables
  assign dvmOn   = st.chanEn[0] && st.swEn[`CSPC_CTRL_DVM_BIT];
  assign snoopOn = st.chanEn[1] && st.swEn[`CSPC_CTRL_SNP_BIT];

  // ****
  // Data store, byte merge and parity
  // ****
  assign loadIdx  = arHs ? araddr[`CSPC_MEM_IDX_LSB +: `CSPC_MEM_IDX_W] : st.rIdx + 1'b1;
  assign loadWord = st.mem[loadIdx];
  assign oldWord  = st.mem[st.wrIdx];

  // [RQ2] Byte lanes under their strobes
  for (genvar i = 0; i < `CSPC_STRB_W; i++) begin : gLane
    assign mergedWord[8*i +: 8] = wstrb[i] ? wdata[8*i +: 8] : oldWord[8*i +: 8];
    assign loadCheck[i]         = ^loadWord[8*i +: 8];
  end

  assign statusWord = {3'h0,
                       FULL_COHERENT,
                       st.wrAcks,
                       st.rdAcks,
                       // [RQ1] Index held inside 0 to 6
                       (PORT_INDEX > `CSPC_PORT_MAX) ? `CSPC_PORT_MAX : PORT_INDEX,
                       st.chanEn,
                       st.cdSeen,
                       st.crResp,
                       (st.phase != CSPC_SN_IDLE)};

  // ****
  // Write response queue
  // ****
  // [RQ4] Evicts queue with a cleared trace bit
  assign fifoPush = (awHs && (awsnoop == `CSPC_AW_EVICT)) || (wHs && wlast);
  assign fifoIn   = wHs ? {st.wrId, st.wrTrace} : {awid, 1'b0};
  assign fifoPop  = (!st.bValid || bHs) && !fifoEmpty;

  cspc_wresp_fifo uWrespFifo (
    .clk    (clk),
    .arst_n (arst_n),
    .push   (fifoPush),
    .din    (fifoIn),
    .pop    (fifoPop),
    .dout   (fifoOut),
    .empty  (fifoEmpty),
    .level  (fifoLevel)
  );

  // ****
  // Next state
  // ****
  always_comb begin
    logic       cmdReq;
    logic [3:0] cmdType;
    cmdReq  = 1'b0;
    cmdType = pwdata[`CSPC_CMD_TYPE_LSB +: 4];
    next_st = st;

    // [RQ18] One capture right after reset release
    if (!st.cfgDone) begin
      next_st.cfgDone = 1'b1;
      next_st.chanEn  = {snoop_channel_enables[1] & FULL_COHERENT, snoop_channel_enables[0]};
    end

    // Register reads are prepared in the setup cycle
    next_st.apbReady = 1'b0;
    if (apbSetup) begin
      next_st.apbReady = 1'b1;
      next_st.apbErr   = 1'b0;
      next_st.apbRdata = 32'h0;
      case (paddr)
        `CSPC_REG_CTRL:   next_st.apbRdata = {30'h0, st.swEn};
        `CSPC_REG_SNADDR: next_st.apbRdata = st.snAddr;
        `CSPC_REG_SNCMD:  next_st.apbRdata = 32'h0;
        `CSPC_REG_STATUS: next_st.apbRdata = statusWord;
        `CSPC_REG_SNDATA: next_st.apbRdata = st.cdWord;
        `CSPC_REG_IDENT:  next_st.apbRdata = {20'h0, st.idents};
        default:          next_st.apbErr   = 1'b1;
      endcase
    end
    if (apbAccess && pwrite) begin
      case (paddr)
        `CSPC_REG_CTRL: begin
          if (pstrb[0]) begin
            next_st.swEn = pwdata[1:0];
          end
        end
        `CSPC_REG_SNADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
              next_st.snAddr[8*b +: 8] = pwdata[8*b +: 8];
            end
          end
        end
        `CSPC_REG_SNCMD: cmdReq = 1'b1;
        default:         cmdReq = 1'b0;
      endcase
    end

    // Write address and data
    if (awHs) begin
      next_st.idents[3:0] = write_req_access_ident;
      if (awsnoop != `CSPC_AW_EVICT) begin
        next_st.wrActive = 1'b1;
        next_st.wrId     = awid;
        next_st.wrTrace  = write_req_trace_in;
        next_st.wrIdx    = awaddr[`CSPC_MEM_IDX_LSB +: `CSPC_MEM_IDX_W];
      end
    end
    if (wHs) begin
      next_st.mem[st.wrIdx] = mergedWord;
      next_st.wrIdx         = st.wrIdx + 1'b1;
      // [RQ3] Last beat closes the burst
      if (wlast) begin
        next_st.wrActive = 1'b0;
      end
    end
    // Leave room for the one in flight; no AW while a burst is open
    next_st.awReady = !next_st.wrActive && (fifoLevel < `CSPC_WFIFO_ROOM);

    // [RQ16] Every queued write answered in order
    if (fifoPop) begin
      next_st.bValid = 1'b1;
      // [RQ20] Identifier from the request
      next_st.bId    = fifoOut[`CSPC_ID_W:1];
      next_st.bTrace = fifoOut[0];
    end else if (bHs) begin
      next_st.bValid = 1'b0;
    end

    // Read bursts, one at a time
    if (arHs) begin
      next_st.rValid      = 1'b1;
      // [RQ20] Read identifier kept
      next_st.rId         = arid;
      // [RQ5] Trace bit travels with the burst
      next_st.rTrace      = read_req_trace_in;
      next_st.rCnt        = arIsDvm ? 8'h0 : arlen;
      next_st.rLast       = arIsDvm || (arlen == 8'h0);
      next_st.rIdx        = loadIdx;
      next_st.rData       = arIsDvm ? '0 : loadWord;
      next_st.rCheck      = arIsDvm ? '0 : loadCheck;
      next_st.idents[7:4] = read_req_access_ident;
    end else if (rHs) begin
      if (st.rLast) begin
        next_st.rValid = 1'b0;
      end else begin
        next_st.rCnt   = st.rCnt - 8'h1;
        next_st.rLast  = (st.rCnt == 8'h1);
        next_st.rIdx   = loadIdx;
        next_st.rData  = loadWord;
        next_st.rCheck = loadCheck;
      end
    end
    next_st.arReady = !next_st.rValid;

    // [RQ8] Snoop data beats
    if (cdHs) begin
      next_st.cdWord = cddata[31:0];
      if (cdlast) begin
        next_st.cdSeen = 1'b1;
      end
    end

    // [RQ11] Snoop issue and completion
    case (st.phase)
      CSPC_SN_IDLE: begin
        if (arHs && arIsDvm && dvmOn) begin
          next_st.phase   = CSPC_SN_ADDR;
          next_st.acValid = 1'b1;
          next_st.acAddr  = araddr;
          next_st.acProt  = arprot;
          next_st.acSnoop = `CSPC_AR_DVM_MSG;
          // [RQ6] VMID from the read request
          next_st.acVmid  = read_req_vmid_ext;
        end else if (cmdReq && ((cmdType[3:1] == 3'h7) ? dvmOn : snoopOn)) begin
          next_st.phase   = CSPC_SN_ADDR;
          next_st.acValid = 1'b1;
          next_st.acAddr  = st.snAddr;
          next_st.acProt  = pwdata[`CSPC_CMD_PROT_LSB +: 3];
          next_st.acSnoop = cmdType;
          // No read request behind this one, so no VMID to carry
          next_st.acVmid  = 4'h0;
        end
      end
      CSPC_SN_ADDR: begin
        if (acHs) begin
          next_st.acValid = 1'b0;
          next_st.cdSeen  = 1'b0;
          next_st.phase   = CSPC_SN_RESP;
        end
      end
      CSPC_SN_RESP: begin
        // [RQ10] Response taken under ready
        if (crHs) begin
          next_st.crResp       = crresp;
          next_st.idents[11:8] = snoop_resp_access_ident;
          if (crresp[0] && FULL_COHERENT && !next_st.cdSeen) begin
            next_st.phase = CSPC_SN_DATA;
          end else begin
            next_st.phase = CSPC_SN_IDLE;
          end
        end
      end
      CSPC_SN_DATA: begin
        if (cdHs && cdlast) begin
          next_st.phase = CSPC_SN_IDLE;
        end
      end
      default: next_st.phase = CSPC_SN_IDLE;
    endcase
    next_st.crReady = (next_st.phase == CSPC_SN_RESP);
    // [RQ9] Ready only while a beat can be taken
    next_st.cdReady = FULL_COHERENT && !next_st.cdSeen &&
                      ((next_st.phase == CSPC_SN_RESP) || (next_st.phase == CSPC_SN_DATA));

    // [RQ12] Completion acknowledges counted
    if (rack && FULL_COHERENT) begin
      next_st.rdAcks = st.rdAcks + 8'h1;
    end
    if (wack && FULL_COHERENT) begin
      next_st.wrAcks = st.wrAcks + 8'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****
  // Outputs
  // ****
  assign pready               = st.apbReady;
  assign prdata               = st.apbRdata;
  assign pslverr              = st.apbErr;
  assign awready              = st.awReady;
  assign wready               = st.wrActive;
  assign bvalid               = st.bValid;
  assign bid                  = st.bId;
  assign bresp                = `CSPC_RESP_OKAY;
  assign write_resp_trace_out = st.bTrace;
  assign arready              = st.arReady;
  assign rvalid               = st.rValid;
  assign rid                  = st.rId;
  assign rdata                = st.rData;
  // [RQ7] Upper two response bits are driven as zero on every port, full-coherent and I/O-coherent alike
  assign rresp                = {2'h0, `CSPC_RESP_OKAY};
  assign rlast                = st.rLast;
  assign read_data_check      = st.rCheck;
  assign read_resp_trace_out  = st.rTrace;
  assign acvalid              = st.acValid;
  assign acaddr               = st.acAddr;
  assign acprot               = st.acProt;
  assign acsnoop              = st.acSnoop;
  assign snoop_vmid_ext       = st.acVmid;
  assign crready              = st.crReady;
  assign cdready              = st.cdReady;

endmodule

/* File: testbench/cspc_port_monitor.sv */
// Handshake and echo checker for the coherent slave port
`timescale 1ns/100ps
// ****
// Checker
// ****
module cspc_port_monitor (
  input logic       clk, arst_n, awvalid, awready, wvalid, wready, wlast, bvalid, bready,
  input logic       arvalid, arready, rvalid, rready, acvalid, acready, cdvalid, cdready, cdlast,
  input logic       write_resp_trace_out, read_req_trace_in, read_resp_trace_out,
  input logic [1:0] snoop_channel_enables,
  input logic [2:0] awsnoop,
  input logic [3:0] arsnoop, acsnoop, read_req_vmid_ext, snoop_vmid_ext,
  input logic [7:0] bid, arid, rid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence sEvict; awvalid && awready && awsnoop == 3'h4; endsequence
  // Forwarded only while the snoop path is idle
  sequence sDvm; arvalid && arready && arsnoop == 4'hf && snoop_channel_enables[0] && !acvalid;
  endsequence
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bid))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rid))
    else $error("read beat dropped");
  AST_AC_HOLD: assert property (acvalid && !acready |=> acvalid && $stable(acsnoop))
    else $error("snoop dropped");
  AST_CD_END: assert property (cdvalid && cdready && cdlast |=> !cdready)
    else $error("snoop data ready after last");
  AST_EVICT: assert property (sEvict |-> ##[1:4] bvalid && !write_resp_trace_out)
    else $error("evict response wrong");
  AST_WR_RESP: assert property (wvalid && wready && wlast |-> ##[1:4] bvalid)
    else $error("write not completed");
  AST_RD_ECHO: assert property (arvalid && arready |=> rvalid && rid == $past(arid)
    && read_resp_trace_out == $past(read_req_trace_in)) else $error("read echo wrong");
  AST_SNP_GATE: assert property (acvalid |-> snoop_channel_enables[acsnoop[3:1] != 3'h7])
    else $error("snoop while disabled");
  AST_DVM_VMID: assert property (sDvm |=> acvalid && snoop_vmid_ext == $past(read_req_vmid_ext))
    else $error("vmid not forwarded");
endmodule
bind cspc_port cspc_port_monitor i_cspc_port_monitor (.*);

/* File: testbench/cspc_master_model.sv */
// Snoop side of the coherent master
`timescale 1ns/100ps
// ****
// Snoop responder
// ****
module cspc_master_model (
  input  logic         clk, arst_n, acvalid, crready, cdready,
  output logic         acready = 1'b0, crvalid = 1'b0, cdvalid = 1'b0, cdlast = 1'b0,
  output logic [4:0]   crresp = 5'h0,
  output logic [127:0] cddata = '0
);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {acready, crvalid, cdvalid, cdlast} <= 4'h0;
    end else begin
      acready <= acvalid && !acready && 1'($urandom);
      if (acvalid && acready) begin
        {crvalid, cdvalid, cdlast} <= 3'h7;
        crresp <= 5'h1;
        cddata <= {4{$urandom}};
      end
      // Released lines toggle so stale values never look valid
      if (crvalid && crready) begin
        crvalid <= 1'b0;
        crresp <= ~crresp;
      end
      if (cdvalid && cdready) begin
        {cdvalid, cdlast} <= 2'h0;
        cddata <= ~cddata;
      end
    end
  end
endmodule

/* File: testbench/cspc_port_tb.sv */
// Self-checking bench for the coherent slave port
`timescale 1ns/100ps
// ****
// Bench
// ****
module cspc_port_tb;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, awvalid = 0, wvalid = 0;
  logic wlast = 0, bready = 0, arvalid = 0, rready = 0, rack = 0, wack = 0;
  logic write_req_trace_in = 0, read_req_trace_in = 0;
  logic [1:0] snoop_channel_enables = '0, awdomain = '0, ardomain = '0;
  logic [2:0] awsnoop = '0, arprot = '0;
  logic [3:0] pstrb = 4'hf, awregion = '0, arregion = '0, arsnoop = '0, read_req_vmid_ext = '0;
  logic [3:0] write_req_access_ident = '0, read_req_access_ident = '0, snoop_resp_access_ident = '0;
  logic [7:0] awid = '0, arid = '0, arlen = '0;
  logic [15:0] wstrb = '0, write_data_check = '0, snoop_data_check = '0;
  logic [31:0] paddr = '0, pwdata = '0, awaddr = '0, araddr = '0, a, p;
  logic [127:0] wdata = '0;
  logic pready, pslverr, awready, wready, bvalid, write_resp_trace_out, arready, rvalid, rlast;
  logic read_resp_trace_out, acvalid, acready, crvalid, crready, cdvalid, cdready, cdlast;
  logic [1:0] bresp;
  logic [2:0] acprot;
  logic [3:0] rresp, acsnoop, snoop_vmid_ext;
  logic [4:0] crresp;
  logic [7:0] bid, rid;
  logic [15:0] read_data_check;
  logic [31:0] prdata, acaddr;
  logic [32:0] rd;
  logic [127:0] rdata, cddata;
  int errCount, checked, i, n, t, k;
  cspc_port i_cspc_port (.*);
  cspc_master_model i_cspc_master_model (.*);
  initial forever #4 clk = ~clk;
  initial begin
    #200000;
    errCount++;
    closeOut;
  end
  task chk(input logic [127:0] s, e);
    checked++;
    if (s !== e) begin
      errCount++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  function logic [15:0] par(input logic [127:0] d);
    for (int j = 0; j < 16; j++) par[j] = ^d[8*j +: 8];
  endfunction
  task closeOut;
    $display("mismatches %0d, checks %0d", errCount, checked);
    if (errCount == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [31:0] ad, d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (!pready);
    rd = {pslverr, prdata};
    {psel, penable} <= 2'h0;
  endtask
  task wr(input logic [2:0] sn);
    @(posedge clk);
    {awid, awaddr, write_req_trace_in, awvalid, awsnoop} <= {$urandom, $urandom, 1'b1, sn};
    {awdomain, awregion, write_req_access_ident} <= $urandom;
    do @(posedge clk); while (!awready);
    awvalid <= 0;
    if (sn != 3'h4) begin
      {wdata, wstrb, wvalid, wlast} <= {{5{$urandom}}, 2'h3};
      do @(posedge clk); while (!wready);
      wvalid <= 0;
    end
    repeat ($urandom_range(3)) @(posedge clk);
    bready <= 1;
    do @(posedge clk); while (!bvalid);
    bready <= 0;
    chk(bid, awid);
    chk({bresp, write_resp_trace_out}, {2'h0, sn == 3'h4 ? 1'b0 : write_req_trace_in});
  endtask
  task rdx(input logic [7:0] len, input logic [3:0] sn);
    @(posedge clk);
    {arid, araddr, read_req_trace_in, arvalid, arlen, arsnoop} <= {$urandom, $urandom, 1'b1, len, sn};
    {arprot, ardomain, arregion, read_req_access_ident, read_req_vmid_ext} <= $urandom;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    for (i = 0; i <= len; i++) begin
      do begin rready <= 1'($urandom); @(posedge clk); end while (!(rvalid && rready));
      chk({rid, rlast, read_resp_trace_out, rresp, read_data_check},
          {arid, i == len, read_req_trace_in, 4'h0, par(rdata)});
    end
    rready <= 0;
  endtask
  initial begin
    void'($urandom(80200));
    for (n = 0; n < 2; n++) begin
      {arst_n, snoop_channel_enables} <= n ? 3'h1 : 3'h3;
      repeat (4) @(posedge clk);
      arst_n <= 1;
      apb(0, 32'h0, 0);
      chk(rd, 0);
      apb(0, 32'h18, 0);
      chk(rd[32], 1);
      apb(1, 32'h0, 32'h3);
      for (t = 0; t < 16; t++) begin
        {a, p} = {$urandom, $urandom};
        apb(1, 32'h4, a);
        apb(1, 32'h8, {p[2:0], t[3:0]});
        if (snoop_channel_enables[t < 14]) begin
          do @(posedge clk); while (!acvalid);
          chk({acaddr, acsnoop, acprot}, {a, t[3:0], p[2:0]});
          do apb(0, 32'hc, 0); while (rd[0]);
          chk(rd[6:1], 6'h21);
        end else begin
          repeat (2) @(posedge clk);
          chk(acvalid, 0);
        end
      end
      rdx(0, 4'hf);
      do apb(0, 32'hc, 0); while (rd[0]);
      chk({rd[28], rd[11:7]}, {4'h8, snoop_channel_enables});
      repeat (20) begin
        wr(3'($urandom));
        rdx(8'($urandom_range(3)), 4'h0);
      end
      k = $urandom_range(9);
      repeat (k) begin
        @(posedge clk);
        {rack, wack} <= 2'h3;
        @(posedge clk);
        {rack, wack} <= 2'h0;
      end
      apb(0, 32'hc, 0);
      chk(rd[27:12], {k[7:0], k[7:0]});
      apb(0, 32'h14, 0);
      chk(rd[7:0], {read_req_access_ident, write_req_access_ident});
    end
    closeOut;
  end
endmodule
